// >>> pkg/ssw_pkg.sv
// Package of constants and carrier types for the supply supervisor and watchdog.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ssw_pkg;

	// Clock rate of the timer clock.
	localparam int unsigned CLK_HZ = 100_000_000;

	// Debounce time in microseconds and its cycle count.
	localparam int unsigned DEBOUNCE_US     = 1000;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);

	// Watchdog intervals in milliseconds and cycle counts.
	localparam int unsigned WDT_MS_0 = 25;
	localparam int unsigned WDT_MS_1 = 200;
	localparam int unsigned WDT_MS_2 = 1400;
	localparam int unsigned WDT_CYC_0 = WDT_MS_0 * (CLK_HZ / 1000);
	localparam int unsigned WDT_CYC_1 = WDT_MS_1 * (CLK_HZ / 1000);
	localparam int unsigned WDT_CYC_2 = WDT_MS_2 * (CLK_HZ / 1000);

	// Reset hold times in milliseconds and cycle counts.
	localparam int unsigned HOLD_MS_0 = 50;
	localparam int unsigned HOLD_MS_1 = 200;
	localparam int unsigned HOLD_MS_2 = 400;
	localparam int unsigned HOLD_MS_3 = 800;
	localparam int unsigned HOLD_CYC_0 = HOLD_MS_0 * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CYC_1 = HOLD_MS_1 * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CYC_2 = HOLD_MS_2 * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CYC_3 = HOLD_MS_3 * (CLK_HZ / 1000);

	// Counter width wide enough for the longest count.
	localparam int unsigned CNT_W = 32;

	// Watchdog select encodings; the fourth code turns the watchdog off.
	localparam logic [1:0] WDT_SEL_0   = 2'h0;
	localparam logic [1:0] WDT_SEL_1   = 2'h1;
	localparam logic [1:0] WDT_SEL_2   = 2'h2;
	localparam logic [1:0] WDT_SEL_OFF = 2'h3;

	// Comparator results from the analog front end.
	typedef struct packed {
		logic primary_above_trip;
		logic primary_above_backup;
		logic second_above_trip;
	} ssw_cmp_t;

	// Two-wire bus line samples.
	typedef struct packed {
		logic scl;
		logic sda;
	} ssw_bus_t;

	// Bus activity tracker states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_START = 3'b010,
		ST_CLKED = 3'b100
	} ssw_bus_state_t;

endpackage

// >>> hw/ssw_top.sv
// Supply supervisor, manual reset, battery switch and bus-restarted watchdog.
`timescale 1ns/1ps
`default_nettype none
module ssw_top
	import ssw_pkg::*;
#(
	parameter int unsigned P_DEBOUNCE = DEBOUNCE_CYCLES,
	parameter int unsigned P_WDT_0    = WDT_CYC_0,
	parameter int unsigned P_WDT_1    = WDT_CYC_1,
	parameter int unsigned P_WDT_2    = WDT_CYC_2,
	parameter int unsigned P_HOLD_0   = HOLD_CYC_0,
	parameter int unsigned P_HOLD_1   = HOLD_CYC_1,
	parameter int unsigned P_HOLD_2   = HOLD_CYC_2,
	parameter int unsigned P_HOLD_3   = HOLD_CYC_3
)
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire ssw_cmp_t   i_cmp,
	input  wire logic       i_manual_reset_in_n,
	input  wire ssw_bus_t   i_bus,
	input  wire logic [1:0] i_wdt_sel_nv,
	input  wire logic [1:0] i_hold_sel_nv,
	input  wire logic [1:0] i_wdt_sel_wdata,
	input  wire logic       i_wdt_sel_we,
	output logic [1:0]      o_wdt_sel_nv,
	output logic            o_wdt_sel_nv_we,
	output logic            o_system_reset,
	output logic            o_watchdog_fault_out_oe,
	output logic            o_early_low_supply_out_oe,
	output logic            o_second_supply_fail_out_oe,
	output logic            o_select_backup
);

	//--------------------------------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------------------------------

	// Two stages for every asynchronous input; only stage two feeds logic.
	// Reset loads ones, the idle level of every line, so no false bus edge,
	// supply drop or button press appears right after reset.
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] async_in;
	assign async_in = {i_cmp, i_manual_reset_in_n, i_bus};

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1_reg <= 6'h3f;
			sync2_reg <= 6'h3f;
		end
		else
		begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end

	logic prim_ok;
	logic prim_gt_bat;
	logic sec_ok;
	logic btn_n_s;
	logic scl_s;
	logic sda_s;
	// Field order matches the concatenation that feeds the first stage.
	assign {prim_ok, prim_gt_bat, sec_ok, btn_n_s, scl_s, sda_s} = sync2_reg;

	//--------------------------------------------------------------------------
	// Nonvolatile watchdog selection
	//--------------------------------------------------------------------------

	// The select mirrors the nonvolatile cell, loaded once after reset release.
	// A write strobe in the load cycle is dropped; the host cannot write that
	// early because system reset is still held then.
	logic [1:0] wdt_sel_reg;
	logic       sel_loaded_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			wdt_sel_reg     <= WDT_SEL_OFF;
			sel_loaded_reg  <= 1'b0;
			o_wdt_sel_nv    <= WDT_SEL_OFF;
			o_wdt_sel_nv_we <= 1'b0;
		end
		else
		begin
			o_wdt_sel_nv_we <= 1'b0;
			if (!sel_loaded_reg)
			begin
				wdt_sel_reg    <= i_wdt_sel_nv;
				o_wdt_sel_nv   <= i_wdt_sel_nv;
				sel_loaded_reg <= 1'b1;
			end
			else if (i_wdt_sel_we)
			begin
				wdt_sel_reg     <= i_wdt_sel_wdata;
				o_wdt_sel_nv    <= i_wdt_sel_wdata;
				o_wdt_sel_nv_we <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Manual reset debounce
	//--------------------------------------------------------------------------

	// The debounced level changes only after the raw level is steady for long.
	// A bounce shorter than the debounce time restarts the count and never
	// reaches the reset; the price is that a real press is seen that late.
	logic             btn_n_db_reg;
	logic [CNT_W-1:0] db_cnt_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			btn_n_db_reg <= 1'b1;
			db_cnt_reg   <= '0;
		end
		else if (btn_n_s == btn_n_db_reg)
		begin
			db_cnt_reg <= '0;
		end
		else if (db_cnt_reg >= CNT_W'(P_DEBOUNCE - 1))
		begin
			btn_n_db_reg <= btn_n_s;
			db_cnt_reg   <= '0;
		end
		else
		begin
			db_cnt_reg <= db_cnt_reg + 1'b1;
		end
	end

	//--------------------------------------------------------------------------
	// System reset hold
	//--------------------------------------------------------------------------

	// Hold time chosen by the two select bits.
	// The select is read live, so a new choice applies to the next release.
	logic [CNT_W-1:0] hold_term;
	always_comb
	begin
		case (i_hold_sel_nv)
			2'h0:    hold_term = CNT_W'(P_HOLD_0);
			2'h1:    hold_term = CNT_W'(P_HOLD_1);
			2'h2:    hold_term = CNT_W'(P_HOLD_2);
			default: hold_term = CNT_W'(P_HOLD_3);
		endcase
	end

	// Any cause restarts the hold count, so release comes one hold after the last.
	logic             rst_cause;
	logic [CNT_W-1:0] hold_cnt_reg;
	// Both causes share one counter, so a press during a supply hold extends it.
	assign rst_cause = !prim_ok || !btn_n_db_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			hold_cnt_reg   <= '0;
			o_system_reset <= 1'b1;
		end
		else if (rst_cause)
		begin
			hold_cnt_reg   <= '0;
			o_system_reset <= 1'b1;
		end
		else if (o_system_reset)
		begin
			if (hold_cnt_reg >= hold_term - 1'b1)
			begin
				o_system_reset <= 1'b0;
			end
			else
			begin
				hold_cnt_reg <= hold_cnt_reg + 1'b1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Supply outputs and battery switch
	//--------------------------------------------------------------------------

	// Comparator levels pass straight through with no hold applied.
	// The second-supply output bypasses the hold counter on purpose.
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_early_low_supply_out_oe   <= 1'b1;
			o_second_supply_fail_out_oe <= 1'b1;
			o_select_backup             <= 1'b0;
		end
		else
		begin
			o_early_low_supply_out_oe   <= !prim_ok;
			o_second_supply_fail_out_oe <= !sec_ok;
			o_select_backup             <= !prim_ok && !prim_gt_bat;
		end
	end

	//--------------------------------------------------------------------------
	// Bus activity detector
	//--------------------------------------------------------------------------

	// Start is sda falling with scl high; a clock low then stop completes it.
	// The start is remembered until a clock low follows, so a start and a stop
	// with no clock between them never restart the watchdog.
	logic           scl_d_reg;
	logic           sda_d_reg;
	ssw_bus_state_t bus_st_reg;
	logic           kick_reg;
	logic           start_ev;
	logic           stop_ev;
	assign start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_ev  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_d_reg  <= 1'b1;
			sda_d_reg  <= 1'b1;
			bus_st_reg <= ST_IDLE;
			kick_reg   <= 1'b0;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			kick_reg  <= 1'b0;
			case (bus_st_reg)
				ST_IDLE:
					if (start_ev)
						bus_st_reg <= ST_START;
				ST_START:
					if (scl_d_reg && !scl_s)
						bus_st_reg <= ST_CLKED;
				ST_CLKED:
					if (stop_ev)
					begin
						bus_st_reg <= ST_IDLE;
						kick_reg   <= 1'b1;
					end
					else if (start_ev)
						bus_st_reg <= ST_START;
				default:
					bus_st_reg <= ST_IDLE;
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Watchdog timer
	//--------------------------------------------------------------------------

	// Terminal count from the three presets; the fourth code disables it.
	// The zero term of that code is never compared, because the timer block
	// holds the counter clear while the select is off.
	logic [CNT_W-1:0] wdt_term;
	always_comb
	begin
		case (wdt_sel_reg)
			WDT_SEL_0: wdt_term = CNT_W'(P_WDT_0);
			WDT_SEL_1: wdt_term = CNT_W'(P_WDT_1);
			WDT_SEL_2: wdt_term = CNT_W'(P_WDT_2);
			default:   wdt_term = '0;
		endcase
	end

	// Timer idles during system reset; a restart clears an expired fault.
	// Holding it clear in reset keeps a slow boot from reading as a hang.
	logic [CNT_W-1:0] wdt_cnt_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			wdt_cnt_reg             <= '0;
			o_watchdog_fault_out_oe <= 1'b0;
		end
		else if (kick_reg || o_system_reset || wdt_sel_reg == WDT_SEL_OFF)
		begin
			wdt_cnt_reg             <= '0;
			o_watchdog_fault_out_oe <= 1'b0;
		end
		else if (wdt_cnt_reg >= wdt_term - 1'b1)
		begin
			o_watchdog_fault_out_oe <= 1'b1;
		end
		else
		begin
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
		end
	end

endmodule
`default_nettype wire

// >>> dv/ssw_chk.sv
// Checker of the supervisor and watchdog port timing.
`timescale 1ns/1ps
`default_nettype none
module ssw_chk
	import ssw_pkg::*;
#(
	parameter int unsigned P_HOLD_3 = HOLD_CYC_3
)
(
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	input wire ssw_cmp_t   i_cmp,
	input wire logic       i_manual_reset_in_n,
	input wire logic [1:0] i_wdt_sel_wdata,
	input wire logic       i_wdt_sel_we,
	input wire logic [1:0] o_wdt_sel_nv,
	input wire logic       o_wdt_sel_nv_we,
	input wire logic       o_system_reset,
	input wire logic       o_watchdog_fault_out_oe,
	input wire logic       o_early_low_supply_out_oe,
	input wire logic       o_second_supply_fail_out_oe,
	input wire logic       o_select_backup
);
	//------------------------------------------------------------
	// Port relations
	//------------------------------------------------------------
	// Release bound is the longest hold plus the input pipeline.
	localparam int REL_MAX = P_HOLD_3 + 8;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// Comparator results reach the pins three edges later.
	chk_low_warn: assert property (
		$fell(i_cmp.primary_above_trip) |-> ##3 o_early_low_supply_out_oe)
		else $error("low warning late");
	chk_second_clear: assert property (
		$rose(i_cmp.second_above_trip) |-> ##3 !o_second_supply_fail_out_oe)
		else $error("second fail not released");
	chk_backup_sel: assert property (
		$changed(i_cmp) |-> ##3 (o_select_backup == (!$past(i_cmp.primary_above_trip, 3)
		&& !$past(i_cmp.primary_above_backup, 3))))
		else $error("supply select wrong");
	chk_reset_drop: assert property (
		$fell(i_cmp.primary_above_trip) |-> ##3 o_system_reset)
		else $error("reset late on drop");
	chk_reset_hold: assert property (
		$rose(i_cmp.primary_above_trip) && i_manual_reset_in_n
		|-> o_system_reset [*8] ##[1:REL_MAX] !o_system_reset)
		else $error("reset hold wrong");
	chk_nv_echo: assert property (
		i_wdt_sel_we |=> o_wdt_sel_nv_we && o_wdt_sel_nv == $past(i_wdt_sel_wdata))
		else $error("select store wrong");
	chk_fault_clear: assert property (
		o_system_reset [*2] |-> !o_watchdog_fault_out_oe)
		else $error("fault during reset");
	// A press must not reach the reset for eight cycles after it falls.
	chk_button_filter: assert property (
		$fell(i_manual_reset_in_n) && !o_system_reset |=> !o_system_reset [*8])
		else $error("button not debounced");
endmodule
bind ssw_top ssw_chk #(.P_HOLD_3(P_HOLD_3)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmp(i_cmp),
	.i_manual_reset_in_n(i_manual_reset_in_n), .i_wdt_sel_wdata(i_wdt_sel_wdata),
	.i_wdt_sel_we(i_wdt_sel_we), .o_wdt_sel_nv(o_wdt_sel_nv),
	.o_wdt_sel_nv_we(o_wdt_sel_nv_we), .o_system_reset(o_system_reset),
	.o_watchdog_fault_out_oe(o_watchdog_fault_out_oe),
	.o_early_low_supply_out_oe(o_early_low_supply_out_oe),
	.o_second_supply_fail_out_oe(o_second_supply_fail_out_oe),
	.o_select_backup(o_select_backup));
`default_nettype wire

// >>> dv/ssw_host.sv
// Host model that restarts the watchdog over the two bus lines.
`timescale 1ns/1ps
`default_nettype none
module ssw_host
	import ssw_pkg::*;
(
	input  wire logic   i_clk_sys,
	output var ssw_bus_t o_bus
);
	//------------------------------------------------------------
	// Bus sequences
	//------------------------------------------------------------
	// Both lines rest high through their pull-ups.
	initial o_bus = 2'h3;
	// One bus level, held gap clocks so the block sees it settled.
	task automatic step(input ssw_bus_t v, input int gap);
		@(negedge i_clk_sys);
		o_bus = v;
		repeat (gap) @(negedge i_clk_sys);
	endtask
	// Start, clock low and high, stop; without the pulse it must not count.
	task automatic restart(input int gap, input bit with_clk);
		step(2'h2, gap);
		if (with_clk)
		begin
			step(2'h0, gap);
			step(2'h2, gap);
		end
		step(2'h3, gap);
	endtask
endmodule
`default_nettype wire

// >>> dv/ssw_top_test.sv
// Self-checking bench for the supply supervisor and watchdog.
`timescale 1ns/1ps
`default_nettype none
module ssw_top_test
	import ssw_pkg::*;
;
	//------------------------------------------------------------
	// Stimulus, expectations and verdict
	//------------------------------------------------------------
	localparam int DB = 8;
	localparam int W0 = 40;
	localparam int W1 = 60;
	localparam int W2 = 80;
	localparam int H0 = 10;
	localparam int H1 = 14;
	localparam int H2 = 18;
	localparam int H3 = 22;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	ssw_cmp_t   cmp = 3'h7;
	logic       btn_n = 1'b1;
	logic [1:0] nvs = WDT_SEL_0;
	logic [1:0] wdat = 2'h0;
	logic       we = 1'b0;
	logic [1:0] hsel = 2'h0;
	ssw_bus_t   bus;
	logic [1:0] nv;
	logic       nv_we, sysrst, fault, low, v2f, bkp;
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         seed = 59;
	// Short counts keep the run brief.
	ssw_top #(.P_DEBOUNCE(DB), .P_WDT_0(W0), .P_WDT_1(W1), .P_WDT_2(W2),
		.P_HOLD_0(H0), .P_HOLD_1(H1), .P_HOLD_2(H2), .P_HOLD_3(H3)) uut (
		.i_clk_sys(clk), .i_rst(rst), .i_cmp(cmp), .i_manual_reset_in_n(btn_n),
		.i_bus(bus), .i_wdt_sel_nv(nvs), .i_hold_sel_nv(hsel),
		.i_wdt_sel_wdata(wdat), .i_wdt_sel_we(we), .o_wdt_sel_nv(nv),
		.o_wdt_sel_nv_we(nv_we), .o_system_reset(sysrst),
		.o_watchdog_fault_out_oe(fault), .o_early_low_supply_out_oe(low),
		.o_second_supply_fail_out_oe(v2f), .o_select_backup(bkp));
	ssw_host u_host (.i_clk_sys(clk), .o_bus(bus));
	// Clock of 10 ns period.
	always #5 clk = ~clk;
	// Expected counts follow the parameters set above.
	function automatic int hold_of(input int s);
		return (s == 0) ? H0 : (s == 1) ? H1 : (s == 2) ? H2 : H3;
	endfunction
	function automatic int wdt_of(input int s);
		return (s == 0) ? W0 : (s == 1) ? W1 : W2;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input string nm, input logic [1:0] e, input logic [1:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hung run counts as a mismatch.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			test_done();
		end
	end
	// Main sequence; inputs change on the falling edge.
	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(4);
		check("reset", 1'b1, sysrst);
		cyc(hold_of(0) + 8);
		check("reset", 1'b0, sysrst);
		repeat (16)
		begin
			cmp = 3'($random(seed));
			hsel = 2'($random(seed));
			cyc(32);
			check("low", !cmp.primary_above_trip, low);
			check("v2f", !cmp.second_above_trip, v2f);
			check("bkp", !cmp[2] && !cmp[1], bkp);
			check("reset", !cmp.primary_above_trip, sysrst);
		end
		cmp = 3'h7;
		cyc(32);
		for (int s = 0; s < 4; s++)
		begin
			hsel = 2'(s);
			cmp.primary_above_trip = 1'b0;
			cyc(6);
			check("reset", 1'b1, sysrst);
			cmp.primary_above_trip = 1'b1;
			cyc(hold_of(s));
			check("reset", 1'b1, sysrst);
			cyc(8);
			check("reset", 1'b0, sysrst);
		end
		// Contact bounce shorter than the debounce time.
		repeat (4)
		begin
			btn_n = 1'b0;
			cyc(2);
			btn_n = 1'b1;
			cyc(2);
		end
		cyc(12);
		check("reset", 1'b0, sysrst);
		btn_n = 1'b0;
		cyc(DB + 6);
		check("reset", 1'b1, sysrst);
		btn_n = 1'b1;
		cyc(hold_of(3));
		check("reset", 1'b1, sysrst);
		cyc(DB + 8);
		check("reset", 1'b0, sysrst);
		repeat (4)
		begin
			u_host.restart(3, 1'b1);
			cyc(14);
			check("fault", 1'b0, fault);
		end
		cyc(46);
		check("fault", 1'b1, fault);
		u_host.restart(5, 1'b1);
		cyc(5);
		check("fault", 1'b0, fault);
		u_host.restart(3, 1'b0);
		cyc(32);
		check("fault", 1'b1, fault);
		// Every select code, the last one switching the watchdog off.
		for (int s = 0; s < 4; s++)
		begin
			wdat = 2'(s);
			we = 1'b1;
			cyc(1);
			we = 1'b0;
			check("nv", 2'(s), nv);
			check("nv_we", 1'b1, nv_we);
			u_host.restart(3, 1'b1);
			check("nv_we", 1'b0, nv_we);
			cyc(wdt_of(s) - 6);
			check("fault", 1'b0, fault);
			cyc(12);
			check("fault", s < 3, fault);
		end
		// A reset in mid-run must reload the stored select, here the second one.
		nvs = WDT_SEL_1;
		rst = 1'b1;
		cyc(3);
		check("reset", 1'b1, sysrst);
		check("fault", 1'b0, fault);
		rst = 1'b0;
		cyc(1);
		check("nv", WDT_SEL_1, nv);
		cyc(hold_of(3) + 7);
		check("reset", 1'b0, sysrst);
		cyc(wdt_of(1) - 10);
		check("fault", 1'b0, fault);
		cyc(12);
		check("fault", 1'b1, fault);
		test_done();
	end
endmodule
`default_nettype wire
